// ---- verilog/strobed_port_pkg.sv ----
// constants, register map and field layout of the strobed parallel port
package strobed_port_pkg;
  // register byte addresses on the register bus
  localparam logic [7:0] data_addr = 8'h00;
  localparam logic [7:0] ctrl_addr = 8'h04;
  localparam logic [7:0] inbuf_addr = 8'h08;
  localparam logic [7:0] irq_stat_addr = 8'h0c;
  localparam logic [7:0] irq_mask_addr = 8'h10;
  // control/status field positions
  localparam int in_full_bit = 0;
  localparam int out_full_bit = 1;
  localparam int in_mode_bit = 2;
  localparam int out_clr_bit = 3;
  localparam int a_mode_lo = 4;
  localparam int b_mode_lo = 6;
  localparam logic [7:0] ctrl_reset = 8'hfc;
  localparam logic [7:0] data_reset = 8'hff;
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;
  // interrupt status bits
  localparam int irq_in_full = 0;
  localparam int irq_out_empty = 1;
  localparam int irq_width = 2;
  // flag pin modes
  typedef enum logic [1:0] {
    flag_low = 2'b00,
    flag_high = 2'b01,
    flag_status = 2'b10,
    flag_input = 2'b11
  } flag_mode_e;
  typedef enum logic [1:0] {
    bus_idle = 2'b00,
    bus_wresp = 2'b01,
    bus_rresp = 2'b10
  } bus_state_e;
endpackage

// ---- verilog/strobe_sync.sv ----
// two-stage synchroniser with edge detection for one strobe or flag pin
module strobe_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic pin_in,
  output logic level,
  output logic fall,
  output logic rise
);
  typedef struct packed {
    logic meta_r;
    logic sync_r;
    logic prev_r;
  } sync_s;
  sync_s st_r;
  sync_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.meta_r = pin_in;
    st_nxt.sync_r = st_r.meta_r;
    st_nxt.prev_r = st_r.sync_r;
  end

  // idle strobes rest high, so reset state avoids a false edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level = st_r.sync_r;
  assign fall = st_r.prev_r & ~st_r.sync_r;
  assign rise = ~st_r.prev_r & st_r.sync_r;
endmodule

// ---- verilog/strobed_parallel_port.sv ----
// strobed parallel port: pins, flag logic and register slave
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
module strobed_parallel_port (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [7:0] strobed_port_data_in,
  output logic [7:0] strobed_port_data_out,
  output logic [7:0] strobed_port_data_oe,
  input wire logic out_strobe_n,
  input wire logic in_strobe_n,
  input wire logic flag_pin_a_in,
  output logic flag_pin_a_out,
  output logic flag_pin_a_oe,
  input wire logic flag_pin_b_in,
  output logic flag_pin_b_out,
  output logic flag_pin_b_oe,
  output logic irq
);
  import strobed_port_pkg::*;

  typedef struct packed {
    logic [7:0] data_r;
    logic [7:0] ctrl_r;
    logic [7:0] inbuf_r;
    logic [irq_width-1:0] stat_r;
    logic [irq_width-1:0] mask_r;
    bus_state_e bus_r;
    logic aw_got_r;
    logic w_got_r;
    logic [7:0] awaddr_r;
    logic [7:0] wbyte_r;
    logic wlane_r;
    logic awready_r;
    logic wready_r;
    logic arready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [7:0] pin_out_r;
    logic [7:0] pin_oe_r;
    logic a_out_r;
    logic a_oe_r;
    logic b_out_r;
    logic b_oe_r;
    logic irq_r;
  } port_s;
  port_s st_r;
  port_s st_nxt;

  logic ostb_lvl, ostb_fall, ostb_rise;
  logic istb_lvl, istb_fall, istb_rise;
  logic a_lvl, b_lvl;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // strobes synchronised first
  strobe_sync u_ostb (.clk(clk), .reset(reset), .pin_in(out_strobe_n),
    .level(ostb_lvl), .fall(ostb_fall), .rise(ostb_rise));
  strobe_sync u_istb (.clk(clk), .reset(reset), .pin_in(in_strobe_n),
    .level(istb_lvl), .fall(istb_fall), .rise(istb_rise));
  strobe_sync u_afl (.clk(clk), .reset(reset), .pin_in(flag_pin_a_in),
    .level(a_lvl), .fall(), .rise());
  strobe_sync u_bfl (.clk(clk), .reset(reset), .pin_in(flag_pin_b_in),
    .level(b_lvl), .fall(), .rise());

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [1:0] a_mode;
    logic [1:0] b_mode;
    logic port_gate_n;
    logic out_always;
    logic istb_ok;
    logic do_write;
    logic do_read;
    logic [7:0] wa;
    logic [7:0] wd;
    logic [7:0] src;
    logic [irq_width-1:0] ev;
    a_mode = 2'b00;
    b_mode = 2'b00;
    port_gate_n = 1'b0;
    out_always = 1'b0;
    istb_ok = 1'b0;
    do_write = 1'b0;
    do_read = 1'b0;
    wa = 8'h00;
    wd = 8'h00;
    src = 8'h00;
    ev = '0;
    st_nxt = st_r;

    a_mode = st_r.ctrl_r[a_mode_lo +: 2];
    b_mode = st_r.ctrl_r[b_mode_lo +: 2];
    out_always = (b_mode[1] == 1'b0) && (a_mode == flag_status);
    // gate pin high disables port and input strobe
    port_gate_n = (b_mode == flag_input) ? b_lvl : 1'b0;
    istb_ok = ~port_gate_n;

    // ---- register bus: write path, address and data in any order
    st_nxt.awready_r = 1'b0;
    st_nxt.wready_r = 1'b0;
    st_nxt.arready_r = 1'b0;
    if (awvalid && st_r.awready_r) begin
      st_nxt.aw_got_r = 1'b1;
      st_nxt.awaddr_r = awaddr;
    end
    if (wvalid && st_r.wready_r) begin
      st_nxt.w_got_r = 1'b1;
      st_nxt.wbyte_r = wdata[7:0];
      st_nxt.wlane_r = wstrb[0];
    end
    if (st_r.bus_r == bus_idle) begin
      st_nxt.awready_r = ~st_nxt.aw_got_r & awvalid & ~(awvalid & st_r.awready_r);
      st_nxt.wready_r = ~st_nxt.w_got_r & wvalid & ~(wvalid & st_r.wready_r);
      if (st_r.aw_got_r && st_r.w_got_r) begin
        do_write = st_r.wlane_r;
        wa = st_r.awaddr_r;
        wd = st_r.wbyte_r;
        st_nxt.aw_got_r = 1'b0;
        st_nxt.w_got_r = 1'b0;
        st_nxt.bvalid_r = 1'b1;
        st_nxt.bresp_r = (wa == data_addr || wa == ctrl_addr || wa == inbuf_addr ||
          wa == irq_stat_addr || wa == irq_mask_addr) ? resp_okay : resp_slverr;
        st_nxt.bus_r = bus_wresp;
      end else if (arvalid && st_r.arready_r) begin
        do_read = 1'b1;
        st_nxt.rvalid_r = 1'b1;
        st_nxt.rresp_r = resp_okay;
        st_nxt.rdata_r = 32'h0000_0000;
        case (araddr)
          data_addr: st_nxt.rdata_r[7:0] = st_r.data_r;
          ctrl_addr: st_nxt.rdata_r[7:0] = st_r.ctrl_r;
          inbuf_addr: st_nxt.rdata_r[7:0] = st_r.inbuf_r;
          irq_stat_addr: st_nxt.rdata_r[irq_width-1:0] = st_r.stat_r;
          irq_mask_addr: st_nxt.rdata_r[irq_width-1:0] = st_r.mask_r;
          default: st_nxt.rresp_r = resp_slverr;
        endcase
        st_nxt.bus_r = bus_rresp;
      end else if (!st_r.aw_got_r && !st_r.w_got_r) begin
        st_nxt.arready_r = arvalid & ~st_r.arready_r;
      end
    end
    case (st_r.bus_r)
      bus_wresp: begin
        if (bready) begin
          st_nxt.bvalid_r = 1'b0;
          st_nxt.bus_r = bus_idle;
        end
      end
      bus_rresp: begin
        if (rready) begin
          st_nxt.rvalid_r = 1'b0;
          st_nxt.bus_r = bus_idle;
        end
      end
      bus_idle: begin
      end
      default: st_nxt.bus_r = bus_idle;
    endcase

    // ---- register writes; buffer-full flags stay read-only
    if (do_write) begin
      case (wa)
        data_addr: st_nxt.data_r = wd;
        ctrl_addr: st_nxt.ctrl_r[7:in_mode_bit] = wd[7:in_mode_bit];
        irq_stat_addr: st_nxt.stat_r = st_r.stat_r & ~wd[irq_width-1:0];
        irq_mask_addr: st_nxt.mask_r = wd[irq_width-1:0];
        default: st_nxt.ctrl_r = st_nxt.ctrl_r;
      endcase
    end

    // ---- output-buffer-full flag; set beats clear
    // clear edge chosen by config bit
    if (st_r.ctrl_r[out_clr_bit] ? ostb_rise : ostb_fall) begin
      st_nxt.ctrl_r[out_full_bit] = 1'b0;
      ev[irq_out_empty] = st_r.ctrl_r[out_full_bit];
    end
    if (do_write && wa == data_addr) begin
      st_nxt.ctrl_r[out_full_bit] = 1'b1;
    end

    // ---- input latch and input-buffer-full flag
    // input buffer read clears in-full
    if (do_read && araddr == inbuf_addr) begin
      st_nxt.ctrl_r[in_full_bit] = 1'b0;
    end
    // transparent while low, or capture on rise
    if (istb_ok) begin
      if (st_r.ctrl_r[in_mode_bit]) begin
        if (!istb_lvl) begin
          st_nxt.inbuf_r = strobed_port_data_in;
        end
      end else if (istb_rise) begin
        st_nxt.inbuf_r = strobed_port_data_in;
      end
      if (st_r.ctrl_r[in_mode_bit] ? istb_fall : istb_rise) begin
        st_nxt.ctrl_r[in_full_bit] = 1'b1;
        ev[irq_in_full] = 1'b1;
      end
    end

    // ---- interrupt status, set wins over write-one clear
    st_nxt.stat_r = st_nxt.stat_r | ev;
    st_nxt.irq_r = |(st_nxt.stat_r & st_nxt.mask_r);

    // ---- port pins
    // outside party drives the select pin
    // select pin: 0 data register, 1 control/status
    src = (a_mode == flag_input && a_lvl) ? st_nxt.ctrl_r : st_nxt.data_r;
    st_nxt.pin_out_r = src;
    // push-pull: all eight bits driven or all released together
    // driver mode drives only while out strobe low
    if (port_gate_n) begin
      st_nxt.pin_oe_r = 8'h00;
    end else if (out_always || !ostb_lvl) begin
      st_nxt.pin_oe_r = 8'hff;
    end else begin
      st_nxt.pin_oe_r = 8'h00;
    end

    // ---- flag pins
    // flag pin a level or out-full mirror
    st_nxt.a_oe_r = (a_mode != flag_input);
    st_nxt.a_out_r = (a_mode == flag_status) ? st_nxt.ctrl_r[out_full_bit] : a_mode[0];
    // flag pin b level or in-full mirror
    st_nxt.b_oe_r = (b_mode != flag_input);
    st_nxt.b_out_r = (b_mode == flag_status) ? st_nxt.ctrl_r[in_full_bit] : b_mode[0];
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // reset loads fc, flags clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
      st_r.ctrl_r <= ctrl_reset;
      st_r.data_r <= data_reset;
      st_r.bus_r <= bus_idle;
      st_r.a_oe_r <= 1'b0;
      st_r.b_oe_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign awready = st_r.awready_r;
  assign wready = st_r.wready_r;
  assign arready = st_r.arready_r;
  assign bvalid = st_r.bvalid_r;
  assign bresp = st_r.bresp_r;
  assign rvalid = st_r.rvalid_r;
  assign rdata = st_r.rdata_r;
  assign rresp = st_r.rresp_r;
  assign strobed_port_data_out = st_r.pin_out_r;
  assign strobed_port_data_oe = st_r.pin_oe_r;
  assign flag_pin_a_out = st_r.a_out_r;
  assign flag_pin_a_oe = st_r.a_oe_r;
  assign flag_pin_b_out = st_r.b_out_r;
  assign flag_pin_b_oe = st_r.b_oe_r;
  assign irq = st_r.irq_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  out_full_set_a: assert property (@(posedge clk) disable iff (reset)
    (st_r.bus_r == bus_idle && st_r.aw_got_r && st_r.w_got_r && st_r.wlane_r &&
     st_r.awaddr_r == data_addr) |=> st_r.ctrl_r[out_full_bit])
    else $error("out-full not set by data write");
  out_full_clr_a: assert property (@(posedge clk) disable iff (reset)
    ((st_r.ctrl_r[out_clr_bit] ? ostb_rise : ostb_fall) && !(st_r.bus_r == bus_idle &&
     st_r.aw_got_r && st_r.w_got_r)) |=> !st_r.ctrl_r[out_full_bit])
    else $error("out-full not cleared by strobe edge");
  in_full_set_a: assert property (@(posedge clk) disable iff (reset)
    (!st_r.ctrl_r[in_mode_bit] && istb_rise && !(b_lvl && st_r.ctrl_r[7:6] == flag_input))
    |=> st_r.ctrl_r[in_full_bit])
    else $error("in-full not set on rising edge");
  gate_off_a: assert property (@(posedge clk) disable iff (reset)
    (st_r.ctrl_r[7:6] == flag_input && b_lvl) |=> (strobed_port_data_oe == 8'h00))
    else $error("port driven while gated off");
  drive_mode_a: assert property (@(posedge clk) disable iff (reset)
    (st_r.ctrl_r[7:4] == 4'h0 && ostb_lvl) |=> (strobed_port_data_oe == 8'h00))
    else $error("port driven while strobe high");
  always_on_a: assert property (@(posedge clk) disable iff (reset)
    (st_r.ctrl_r[7:4] == 4'b0010) |=> (strobed_port_data_oe == 8'hff))
    else $error("output-always port not driven");
  select_ctrl_a: assert property (@(posedge clk) disable iff (reset)
    (st_r.ctrl_r[5:4] == flag_input && a_lvl) ##1 (st_r.ctrl_r == $past(st_r.ctrl_r))
    |-> (strobed_port_data_out == st_r.ctrl_r))
    else $error("select pin does not route status");
  flag_a_mirror_a: assert property (@(posedge clk) disable iff (reset)
    (st_r.ctrl_r[5:4] == flag_status) |=> (flag_pin_a_out == st_r.ctrl_r[out_full_bit]))
    else $error("flag pin a does not mirror out-full");
  flag_b_mirror_a: assert property (@(posedge clk) disable iff (reset)
    (st_r.ctrl_r[7:6] == flag_status) |=> (flag_pin_b_out == st_r.ctrl_r[in_full_bit]))
    else $error("flag pin b does not mirror in-full");
endmodule

// ---- tb/port_host.sv ----
// behavioural host on the far side of the strobed port
module port_host (
  input wire logic clk,
  input wire logic [7:0] data_out,
  input wire logic [7:0] data_oe,
  input wire logic a_out,
  input wire logic a_oe,
  input wire logic b_out,
  input wire logic b_oe,
  output logic [7:0] data_in,
  output logic out_strobe_n,
  output logic in_strobe_n,
  output logic a_in,
  output logic b_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] val;
  logic drv, a_drv, a_val, b_drv, b_val;
  // ---
  // pins
  // ---
  // pull-ups win wherever nobody drives
  assign data_in = (data_oe & data_out) | (~data_oe & (drv ? val : 8'hff));
  assign a_in = a_oe ? a_out : (a_drv ? a_val : 1'b1);
  assign b_in = b_oe ? b_out : (b_drv ? b_val : 1'b1);
  initial begin
    val = 8'h00;
    drv = 1'b0;
    {a_drv, a_val, b_drv, b_val} = 4'h0;
    out_strobe_n = 1'b1;
    in_strobe_n = 1'b1;
  end
  // ---
  // host actions
  // ---
  // strobe low opens drivers
  task automatic out_level(input logic lv);
    @(posedge clk);
    out_strobe_n <= lv;
  endtask
  task automatic in_low(input logic [7:0] v);
    @(posedge clk);
    val <= v;
    drv <= 1'b1;
    in_strobe_n <= 1'b0;
  endtask
  // data held past the sync delay, then let go
  task automatic in_high();
    @(posedge clk);
    in_strobe_n <= 1'b1;
    repeat (8) @(posedge clk);
    drv <= 1'b0;
  endtask
  task automatic flags(input logic ad, input logic av, input logic bd, input logic bv);
    @(posedge clk);
    {a_drv, a_val, b_drv, b_val} <= {ad, av, bd, bv};
  endtask
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the strobed parallel port
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import strobed_port_pkg::*;
  logic clk, reset, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0] awaddr, araddr, pin_in, pin_out, pin_oe, d, v;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic ostb_n, istb_n, a_in, a_out, a_oe, b_in, b_out, b_oe, lane;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int err_count, checks, seed_v;

  strobed_parallel_port dut (.clk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .strobed_port_data_in(pin_in), .strobed_port_data_out(pin_out), .strobed_port_data_oe(pin_oe),
    .out_strobe_n(ostb_n), .in_strobe_n(istb_n), .flag_pin_a_in(a_in), .flag_pin_a_out(a_out),
    .flag_pin_a_oe(a_oe), .flag_pin_b_in(b_in), .flag_pin_b_out(b_out), .flag_pin_b_oe(b_oe), .irq);
  port_host host (.clk, .data_out(pin_out), .data_oe(pin_oe), .a_out, .a_oe, .b_out, .b_oe,
    .data_in(pin_in), .out_strobe_n(ostb_n), .in_strobe_n(istb_n), .a_in, .b_in);

  // ---
  // helpers
  // ---
  task automatic chk(input string n, input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // ready and valid are read mid-cycle, where they stand for the next rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] dv, input logic [1:0] r);
    int n;
    logic aw_t, w_t, b_t;
    n = 0;
    b_t = 1'b0;
    bq.push_back(r);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'($urandom), dv};
    wstrb <= {3'($urandom), lane};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_t && n < 100) begin
      @(negedge clk);
      aw_t = (awvalid === 1'b1) && (awready === 1'b1);
      w_t = (wvalid === 1'b1) && (wready === 1'b1);
      b_t = (bvalid === 1'b1);
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    if (!b_t) err_count++;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    logic ar_t, r_t;
    n = 0;
    r_t = 1'b0;
    rq.push_back({r, e});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_t && n < 100) begin
      @(negedge clk);
      ar_t = (arvalid === 1'b1) && (arready === 1'b1);
      r_t = (rvalid === 1'b1);
      @(posedge clk);
      if (ar_t) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    if (!r_t) err_count++;
    @(negedge clk);
  endtask
  // covers sync delay plus the pin register; ends mid-cycle where pins are settled
  task automatic wt();
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ---
  // clock, monitor, watchdog
  // ---
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // responses are looked at mid-cycle, before the edge that hands them over
  always @(negedge clk) begin
    if (rvalid === 1'b1 && rready === 1'b1) chk("rdata", {rresp, rdata}, rq.pop_front());
    if (bvalid === 1'b1 && bready === 1'b1) chk("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end

  // ---
  // scenarios
  // ---
  initial begin
    {reset, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = {1'b1, 51'h0};
    {bready, rready, wstrb, lane} = 7'h01;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    seed_v = $urandom(4706);
    rd(ctrl_addr, {24'h0, ctrl_reset}, resp_okay);
    chk("reset pins", {a_oe, b_oe, pin_oe}, 10'h000);
    wr(ctrl_addr, 8'h00, resp_okay);
    d = 8'($urandom);
    wr(data_addr, d, resp_okay);
    wr(ctrl_addr, 8'h03, resp_okay);
    rd(ctrl_addr, 32'h02, resp_okay);
    chk("flag a low", {a_oe, a_out, pin_oe}, {2'b10, 8'h00});
    host.out_level(1'b0);
    wt();
    chk("driven", {pin_oe, pin_out}, {8'hff, d});
    rd(ctrl_addr, 32'h00, resp_okay);
    host.out_level(1'b1);
    wt();
    chk("released", pin_oe, 8'h00);
    rd(irq_stat_addr, 32'h02, resp_okay);
    wr(irq_mask_addr, 8'h02, resp_okay);
    wt();
    chk("irq on", irq, 1'b1);
    wr(irq_stat_addr, 8'h02, resp_okay);
    wr(irq_mask_addr, 8'h01, resp_okay);
    wt();
    chk("irq off", irq, 1'b0);
    wr(ctrl_addr, 8'h08, resp_okay);
    wr(data_addr, d, resp_okay);
    host.out_level(1'b0);
    wt();
    rd(ctrl_addr, 32'h0a, resp_okay);
    host.out_level(1'b1);
    wt();
    rd(ctrl_addr, 32'h08, resp_okay);
    v = 8'($urandom);
    host.in_low(v);
    wt();
    rd(ctrl_addr, 32'h08, resp_okay);
    host.in_low(~v);
    host.in_high();
    rd(ctrl_addr, 32'h09, resp_okay);
    chk("irq in", irq, 1'b1);
    rd(inbuf_addr, {24'h0, ~v}, resp_okay);
    rd(ctrl_addr, 32'h08, resp_okay);
    wr(irq_stat_addr, 8'h01, resp_okay);
    wt();
    chk("irq clr", irq, 1'b0);
    // transparent latch
    wr(ctrl_addr, 8'h0c, resp_okay);
    host.in_low(v);
    wt();
    rd(ctrl_addr, 32'h0d, resp_okay);
    host.in_low(~v);
    wt();
    rd(inbuf_addr, {24'h0, ~v}, resp_okay);
    host.in_high();
    wt();
    rd(inbuf_addr, {24'h0, ~v}, resp_okay);
    wr(data_addr, d, resp_okay);
    for (int m = 0; m < 3; m++) begin
      wr(ctrl_addr, {m[1:0], m[1:0], 4'h0}, resp_okay);
      wt();
      chk("flag a", {a_oe, a_out}, {1'b1, m != 0});
      chk("flag b", {b_oe, b_out}, {1'b1, m == 1});
    end
    // select input
    wr(ctrl_addr, 8'h30, resp_okay);
    host.flags(1'b1, 1'b0, 1'b0, 1'b0);
    host.out_level(1'b0);
    wt();
    chk("sel data", {a_oe, pin_out}, {1'b0, d});
    host.flags(1'b1, 1'b1, 1'b0, 1'b0);
    wt();
    chk("sel ctrl", pin_out, 8'h30);
    host.out_level(1'b1);
    host.flags(1'b0, 1'b0, 1'b0, 1'b0);
    // gate input
    wr(ctrl_addr, 8'hc0, resp_okay);
    host.flags(1'b0, 1'b0, 1'b1, 1'b1);
    host.out_level(1'b0);
    wt();
    chk("gated", {b_oe, pin_oe}, 9'h000);
    host.in_low(v);
    host.in_high();
    rd(ctrl_addr, 32'hc0, resp_okay);
    host.flags(1'b0, 1'b0, 1'b1, 1'b0);
    wt();
    chk("ungated", pin_oe, 8'hff);
    host.out_level(1'b1);
    host.flags(1'b0, 1'b0, 1'b0, 1'b0);
    // output-always
    wr(ctrl_addr, 8'h20, resp_okay);
    wt();
    chk("always on", pin_oe, 8'hff);
    wr(data_addr, d, resp_okay);
    host.out_level(1'b0);
    wt();
    host.out_level(1'b1);
    wt();
    rd(ctrl_addr, 32'h20, resp_okay);
    chk("still on", pin_oe, 8'hff);
    // write with byte lane 0 off is dropped but answered okay
    lane = 1'b0;
    wr(data_addr, ~d, resp_okay);
    lane = 1'b1;
    rd(ctrl_addr, 32'h20, resp_okay);
    rd(data_addr, {24'h0, d}, resp_okay);
    wr(8'h14, 8'h55, resp_slverr);
    rd(8'h14, 32'h0, resp_slverr);
    tally_and_finish();
  end
endmodule
